// [design/fpl_pkg.sv]
// =====================================================================
// What this block does
// R1: Drive pump output when pump function assigned.
// R2: Valve opens before pump, closes after it.
// R3: Automatic mode uses level state with hysteresis.
// R4: Forced run stops pump only while full.
// R5: Forced stop holds pump off always.
// R6: Source 0 generator, 4 always; absent forces off.
// R7: Off state keeps pump command deasserted.
// R8: Sensor select 0 analogue, 1 contacts.
// R9: Installation wires start and stop contacts.
// R10: Control pump whatever thresholds; use optional levels.
// R11: Thresholds: minimum, low, start below stop, high.
// R12: Contacts assert below level, high above.
// R13: Evaluate level in fixed overriding order.
// R14: Automatic: start, low, minimum switch pump on.
// R15: Automatic: stop, maximum off; hysteresis keeps.
// R16: Operator on/off; refuse start in stop/maximum.
// R17: Over maximum on time: stop, raise fill timeout.
// R18: Acknowledge timeout lets pump restart per mode.
// R19: Block input held for delay: alarm, stop.
// R20: With event enable, pulse on pump on/off.
// R21: After reset pump off, evaluate every tick.
// =====================================================================
package fpl_pkg;

   // =================================================================
   // Timing.
   // =================================================================
   localparam int unsigned FPL_CLK_HZ      = 10_000_000;  // Bus clock.
   localparam int unsigned FPL_TICK_US     = 1000;        // Control tick.
   localparam int unsigned FPL_TICK_CYCLES =
      FPL_TICK_US * (FPL_CLK_HZ / 1_000_000);

   // =================================================================
   // Register byte offsets.
   // =================================================================
   localparam logic [7:0] FPL_CTRL_OFS   = 8'h00;  // Configuration.
   localparam logic [7:0] FPL_CMD_OFS    = 8'h04;  // Operator commands.
   localparam logic [7:0] FPL_START_OFS  = 8'h08;  // Start threshold.
   localparam logic [7:0] FPL_STOP_OFS   = 8'h0C;  // Stop threshold.
   localparam logic [7:0] FPL_MIN_OFS    = 8'h10;  // Minimum threshold.
   localparam logic [7:0] FPL_LOW_OFS    = 8'h14;  // Low threshold.
   localparam logic [7:0] FPL_HIGH_OFS   = 8'h18;  // High threshold.
   localparam logic [7:0] FPL_MAXON_OFS  = 8'h1C;  // Max on time, ticks.
   localparam logic [7:0] FPL_VDLY_OFS   = 8'h20;  // Valve delay, ticks.
   localparam logic [7:0] FPL_BDLY_OFS   = 8'h24;  // Block delay, ticks.
   localparam logic [7:0] FPL_STATUS_OFS = 8'h28;  // Live status.

   // =================================================================
   // Control register fields.
   // =================================================================
   localparam int FPL_CTRL_W      = 13;  // Implemented control bits.
   localparam int FPL_MODE_LSB    = 0;   // Two-bit mode field.
   localparam int FPL_EN_BIT      = 2;   // Zero means off/reset state.
   localparam int FPL_SENS_BIT    = 3;   // Level sensor select.
   localparam int FPL_SRC_LSB     = 4;   // Three-bit power source.
   localparam int FPL_VALVE_BIT   = 7;   // Line valve output used.
   localparam int FPL_EVT_BIT     = 8;   // Pump event enable.
   localparam int FPL_MINU_BIT    = 9;   // Minimum level configured.
   localparam int FPL_LOWU_BIT    = 10;  // Low level configured.
   localparam int FPL_HIGHU_BIT   = 11;  // High level configured.
   localparam int FPL_PUMPFN_BIT  = 12;  // Pump output function given.
   localparam int FPL_CMD_ON_BIT  = 0;   // Operator pump on.
   localparam int FPL_CMD_OFF_BIT = 1;   // Operator pump off.
   localparam int FPL_CMD_ACK_BIT = 2;   // Acknowledge fill timeout.

   // =================================================================
   // Codes and reset values.
   // =================================================================
   localparam logic [1:0] FPL_MODE_AUTO = 2'h0;  // Automatic.
   localparam logic [1:0] FPL_MODE_RUN  = 2'h1;  // Forced run.
   localparam logic [2:0] FPL_SRC_GEN   = 3'h0;  // Generator supplied.
   localparam logic [2:0] FPL_SRC_ALW   = 3'h4;  // Always supplied.
   localparam logic [12:0] FPL_CTRL_RST = 13'h0000;
   localparam logic [15:0] FPL_WORD_RST = 16'h0000;

   // Evaluated level state.
   typedef enum logic [2:0] {
      LV_HYST, LV_START, LV_LOW, LV_MIN, LV_STOP, LV_MAX
   } fpl_lvl_t;

   // Pump and valve sequencing phase.
   typedef enum logic [1:0] {PH_OFF, PH_LEAD, PH_RUN, PH_LAG} fpl_ph_t;

endpackage : fpl_pkg

// [design/fpl_ctrl.sv]
`timescale 1ns/1ps
// =====================================================================
// Fuel transfer pump controller with APB register access.
// =====================================================================
module fpl_ctrl
   import fpl_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = FPL_TICK_CYCLES  // Tick period.
)(
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Level sensing and supply.
   input  wire logic [15:0] level_value,
   input  wire logic        minimum_level_contact,
   input  wire logic        low_level_contact,
   input  wire logic        pump_start_contact,
   input  wire logic        pump_stop_contact,
   input  wire logic        high_level_contact,
   input  wire logic        generator_present,
   input  wire logic        pump_block_input,
   // Drives, alarms and events.
   output logic             pump_output_function,
   output logic             line_valve_output_function,
   output logic             fill_timeout_prealarm,
   output logic             pump_block_prealarm,
   output logic             pump_on_event,
   output logic             pump_off_event
);

   // =================================================================
   // State.
   // =================================================================
   typedef struct packed {
      logic [FPL_CTRL_W-1:0] ctrl;      // Configuration bits.
      logic [15:0]           th_start;  // Start threshold.
      logic [15:0]           th_stop;   // Stop threshold.
      logic [15:0]           th_min;    // Minimum threshold.
      logic [15:0]           th_low;    // Low threshold.
      logic [15:0]           th_high;   // High threshold.
      logic [15:0]           max_on;    // Max on time in ticks.
      logic [15:0]           vdly;      // Valve delay in ticks.
      logic [15:0]           bdly;      // Block delay in ticks.
      logic [23:0]           tick_cnt;  // Tick prescaler.
      logic                  tick;      // One-cycle control tick.
      fpl_lvl_t              lvl;       // Evaluated level state.
      logic                  req;       // Retained pump request.
      fpl_ph_t               phase;     // Sequencing phase.
      logic [15:0]           dly_cnt;   // Valve delay counter.
      logic [15:0]           on_cnt;    // Pump on time counter.
      logic [15:0]           blk_cnt;   // Block input counter.
      logic                  tmo;       // Fill timeout pre-alarm.
      logic                  blk;       // Pump block pre-alarm.
      logic                  pump;      // Pump drive.
      logic                  valve;     // Valve drive.
      logic                  on_evt;    // Pump switched on pulse.
      logic                  off_evt;   // Pump switched off pulse.
      logic [31:0]           prdata;    // Read data.
      logic                  pready;    // Bus answer.
      logic                  pslverr;   // Bus error.
   } fpl_state_t;

   fpl_state_t s;       // Registered state.
   fpl_state_t next_s;  // Next state.

   // Full means the stop or maximum level state.
   function automatic logic fpl_full(input fpl_lvl_t l);
      fpl_full = (l == LV_STOP) || (l == LV_MAX);
   endfunction : fpl_full

   // =================================================================
   // Decoded configuration.
   // =================================================================
   logic [1:0] mode;      // Operating mode.
   logic [2:0] src;       // Power source select.
   logic       en;        // Controller not in off state.
   logic       src_ok;    // Selected source present.
   logic       want;      // Pump should run.
   logic       acc;       // First access cycle.
   logic       wr;        // Write takes effect.
   logic       forced_run_mode;    // Operator on pulse.
   logic       forced_stop_mode;   // Operator off pulse.
   logic       ack;       // Timeout acknowledge pulse.
   logic       b_start;   // Level below start.
   logic       b_low;     // Level below low.
   logic       b_min;     // Level below minimum.
   logic       a_stop;    // Level above stop.
   logic       a_high;    // Level above high.
   fpl_lvl_t   lv;        // Freshly evaluated level.

   // Fixed decodes feeding the main process.
   always_comb begin
      mode    = s.ctrl[FPL_MODE_LSB +: 2];
      src     = s.ctrl[FPL_SRC_LSB +: 3];
      en      = s.ctrl[FPL_EN_BIT];
      // Any other source code counts as absent.
      src_ok  = (src == FPL_SRC_ALW) ||                       // R6
                ((src == FPL_SRC_GEN) && generator_present);  // R6
      acc     = psel && penable && !s.pready;
      wr      = psel && penable && s.pready && pwrite && !s.pslverr;
      forced_run_mode  = wr && (paddr == FPL_CMD_OFS) && pwdata[FPL_CMD_ON_BIT];
      forced_stop_mode = wr && (paddr == FPL_CMD_OFS) && pwdata[FPL_CMD_OFF_BIT];
      ack     = wr && (paddr == FPL_CMD_OFS) && pwdata[FPL_CMD_ACK_BIT];
      // Sensor choice between analogue compare and contacts.
      if (!s.ctrl[FPL_SENS_BIT]) begin  // R8
         b_start = level_value < s.th_start;
         b_low   = level_value < s.th_low;
         b_min   = level_value < s.th_min;
         a_stop  = level_value > s.th_stop;
         a_high  = level_value > s.th_high;
      end else begin  // R8 R12
         b_start = pump_start_contact;
         b_low   = low_level_contact;
         b_min   = minimum_level_contact;
         a_stop  = !pump_stop_contact;
         a_high  = high_level_contact;
      end
      // Later checks override earlier ones.
      lv = LV_HYST;                                              // R13
      if (b_start) lv = LV_START;                                // R13
      if (s.ctrl[FPL_LOWU_BIT] && b_low) lv = LV_LOW;            // R10
      if (s.ctrl[FPL_MINU_BIT] && b_min) lv = LV_MIN;            // R10
      if (a_stop) lv = LV_STOP;                                  // R13
      if (s.ctrl[FPL_HIGHU_BIT] && a_high) lv = LV_MAX;          // R13
      // Every inhibit gates the retained request.
      want = s.req && en && src_ok && !s.tmo && !s.blk &&        // R7
             (mode == FPL_MODE_AUTO || mode == FPL_MODE_RUN);    // R5
   end

   // =================================================================
   // Next state.
   // =================================================================
   always_comb begin
      next_s         = s;
      next_s.tick    = 1'b0;
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
      // Control tick prescaler.
      if (s.tick_cnt >= 24'(TICK_CYCLES - 1)) begin
         next_s.tick_cnt = 24'h00_0000;
         next_s.tick     = 1'b1;
      end else begin
         next_s.tick_cnt = s.tick_cnt + 24'h00_0001;
      end
      // Bus answer one cycle into the access phase.
      if (acc) begin
         next_s.pready = 1'b1;
         next_s.prdata = 32'h0000_0000;
         if (paddr == FPL_CTRL_OFS) begin
            next_s.prdata = 32'(s.ctrl);
         end else if (paddr == FPL_CMD_OFS) begin
            next_s.prdata = 32'h0000_0000;
         end else if (paddr == FPL_START_OFS) begin
            next_s.prdata = 32'(s.th_start);
         end else if (paddr == FPL_STOP_OFS) begin
            next_s.prdata = 32'(s.th_stop);
         end else if (paddr == FPL_MIN_OFS) begin
            next_s.prdata = 32'(s.th_min);
         end else if (paddr == FPL_LOW_OFS) begin
            next_s.prdata = 32'(s.th_low);
         end else if (paddr == FPL_HIGH_OFS) begin
            next_s.prdata = 32'(s.th_high);
         end else if (paddr == FPL_MAXON_OFS) begin
            next_s.prdata = 32'(s.max_on);
         end else if (paddr == FPL_VDLY_OFS) begin
            next_s.prdata = 32'(s.vdly);
         end else if (paddr == FPL_BDLY_OFS) begin
            next_s.prdata = 32'(s.bdly);
         end else if (paddr == FPL_STATUS_OFS) begin
            next_s.prdata = {22'h00_0000, s.phase, s.lvl, s.req,
                             s.blk, s.tmo, s.valve, s.pump};
         end else begin
            // Unmapped address answers with an error.
            next_s.pslverr = 1'b1;
         end
      end
      // Register writes at the completing edge.
      if (wr) begin
         if (paddr == FPL_CTRL_OFS) begin
            next_s.ctrl = pwdata[FPL_CTRL_W-1:0];
         end else if (paddr == FPL_START_OFS) begin
            next_s.th_start = pwdata[15:0];
         end else if (paddr == FPL_STOP_OFS) begin
            next_s.th_stop = pwdata[15:0];
         end else if (paddr == FPL_MIN_OFS) begin
            next_s.th_min = pwdata[15:0];
         end else if (paddr == FPL_LOW_OFS) begin
            next_s.th_low = pwdata[15:0];
         end else if (paddr == FPL_HIGH_OFS) begin
            next_s.th_high = pwdata[15:0];
         end else if (paddr == FPL_MAXON_OFS) begin
            next_s.max_on = pwdata[15:0];
         end else if (paddr == FPL_VDLY_OFS) begin
            next_s.vdly = pwdata[15:0];
         end else if (paddr == FPL_BDLY_OFS) begin
            next_s.bdly = pwdata[15:0];
         end
      end
      // Level evaluation and mode logic on every tick.
      if (s.tick) begin
         next_s.lvl = lv;  // R21
         if (mode == FPL_MODE_AUTO) begin
            if (lv == LV_START || lv == LV_LOW || lv == LV_MIN) begin
               next_s.req = 1'b1;  // R14 R3
            end else if (fpl_full(lv)) begin
               next_s.req = 1'b0;  // R15 R3
            end
         end else if (mode == FPL_MODE_RUN) begin
            next_s.req = !fpl_full(lv);  // R4
         end else begin
            next_s.req = 1'b0;  // R5
         end
      end
      // Operator commands; a start is refused while full.
      if (forced_stop_mode) begin
         next_s.req = 1'b0;  // R16
      end else if (forced_run_mode && !fpl_full(s.lvl)) begin
         next_s.req = 1'b1;  // R16
      end
      // Off state clears the retained command.
      if (!en) begin
         next_s.req = 1'b0;  // R7 R21
      end
      // Fill timeout: acknowledge first so a new trip wins.
      if (ack) begin
         next_s.tmo    = 1'b0;  // R18
         next_s.on_cnt = FPL_WORD_RST;
      end
      if (!s.pump) begin
         next_s.on_cnt = FPL_WORD_RST;
      end else if (s.tick && s.max_on != FPL_WORD_RST) begin
         next_s.on_cnt = s.on_cnt + 16'h0001;
         if (s.on_cnt + 16'h0001 >= s.max_on) begin
            next_s.tmo = 1'b1;  // R17
         end
      end
      // Block input must stay active for its delay.
      if (!pump_block_input) begin
         next_s.blk_cnt = FPL_WORD_RST;
         next_s.blk     = 1'b0;
      end else if (s.tick) begin
         if (s.blk_cnt >= s.bdly) begin
            next_s.blk = 1'b1;  // R19
         end else begin
            next_s.blk_cnt = s.blk_cnt + 16'h0001;
         end
      end
      // Valve and pump sequencing.
      case (s.phase)
         PH_OFF: begin
            next_s.dly_cnt = FPL_WORD_RST;
            if (want) begin
               next_s.phase = s.ctrl[FPL_VALVE_BIT] ? PH_LEAD : PH_RUN;
            end
         end
         PH_LEAD: begin
            if (!want) begin
               next_s.phase = PH_OFF;
            end else if (s.tick) begin
               if (s.dly_cnt >= s.vdly) begin
                  next_s.phase = PH_RUN;  // R2
               end else begin
                  next_s.dly_cnt = s.dly_cnt + 16'h0001;
               end
            end
         end
         PH_RUN: begin
            next_s.dly_cnt = FPL_WORD_RST;
            if (!want) begin
               next_s.phase = s.ctrl[FPL_VALVE_BIT] ? PH_LAG : PH_OFF;
            end
         end
         default: begin
            if (want) begin
               next_s.phase = PH_RUN;
            end else if (s.tick) begin
               if (s.dly_cnt >= s.vdly) begin
                  next_s.phase = PH_OFF;  // R2
               end else begin
                  next_s.dly_cnt = s.dly_cnt + 16'h0001;
               end
            end
         end
      endcase
      // Drives follow the new phase.
      next_s.pump  = (next_s.phase == PH_RUN) &&
                     s.ctrl[FPL_PUMPFN_BIT];                   // R1
      next_s.valve = (next_s.phase != PH_OFF) &&
                     s.ctrl[FPL_PUMPFN_BIT] &&
                     s.ctrl[FPL_VALVE_BIT];                    // R2
      // Event pulses on each switch of the pump.
      next_s.on_evt  = s.ctrl[FPL_EVT_BIT] && next_s.pump && !s.pump;  // R20
      next_s.off_evt = s.ctrl[FPL_EVT_BIT] && !next_s.pump && s.pump; // R20
   end

   // =================================================================
   // State register.
   // =================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s       <= '0;  // R21
         s.ctrl  <= FPL_CTRL_RST;
         s.lvl   <= LV_HYST;
         s.phase <= PH_OFF;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register.
   assign prdata                     = s.prdata;
   assign pready                     = s.pready;
   assign pslverr                    = s.pslverr;
   assign pump_output_function       = s.pump;
   assign line_valve_output_function = s.valve;
   assign fill_timeout_prealarm      = s.tmo;
   assign pump_block_prealarm        = s.blk;
   assign pump_on_event              = s.on_evt;
   assign pump_off_event             = s.off_evt;

   // =================================================================
   // Assertions.
   // =================================================================
   sequence fpl_rise_s;
      $rose(pump_output_function);
   endsequence

   sequence fpl_valve_stable_s;
      $stable(s.ctrl) && s.ctrl[FPL_VALVE_BIT] && s.ctrl[FPL_PUMPFN_BIT];
   endsequence

   AST_OFF_STATE: assert property (  // R7
      @(posedge pclk) disable iff (!presetn)
      !en |=> !pump_output_function)
      else $error("Pump on in off state.");

   AST_SOURCE_ABSENT: assert property (  // R6
      @(posedge pclk) disable iff (!presetn)
      !src_ok |=> !pump_output_function)
      else $error("Pump on without power source.");

   AST_FORCED_STOP: assert property (  // R5
      @(posedge pclk) disable iff (!presetn)
      (mode != FPL_MODE_AUTO && mode != FPL_MODE_RUN)
      |=> !pump_output_function)
      else $error("Pump on in forced stop.");

   AST_VALVE_LEADS: assert property (  // R2
      @(posedge pclk) disable iff (!presetn)
      fpl_rise_s and fpl_valve_stable_s |-> $past(line_valve_output_function))
      else $error("Pump started before valve opened.");

   AST_VALVE_LAGS: assert property (  // R2
      @(posedge pclk) disable iff (!presetn)
      $fell(pump_output_function) and fpl_valve_stable_s
      |-> line_valve_output_function)
      else $error("Valve closed with pump.");

   AST_TIMEOUT_STOPS: assert property (  // R17
      @(posedge pclk) disable iff (!presetn)
      fill_timeout_prealarm |=> !pump_output_function)
      else $error("Pump runs after fill timeout.");

   AST_BLOCK_STOPS: assert property (  // R19
      @(posedge pclk) disable iff (!presetn)
      pump_block_prealarm |=> !pump_output_function)
      else $error("Pump runs while blocked.");

   AST_ON_EVENT: assert property (  // R20
      @(posedge pclk) disable iff (!presetn)
      fpl_rise_s and $past(s.ctrl[FPL_EVT_BIT]) |-> pump_on_event)
      else $error("Missing pump on event.");

   AST_FORCED_RUN: assert property (  // R4
      @(posedge pclk) disable iff (!presetn)
      s.tick && mode == FPL_MODE_RUN && !fpl_full(lv) && !forced_stop_mode && en
      |=> s.req)
      else $error("Forced run did not request pump.");

   AST_MANUAL_REFUSE: assert property (  // R16
      @(posedge pclk) disable iff (!presetn)
      !s.req && forced_run_mode && fpl_full(s.lvl) && !s.tick |=> !s.req)
      else $error("Manual start accepted while full.");

endmodule : fpl_ctrl

// [sim/fpl_level_model.sv]
`timescale 1ns/1ps
// ==========================================================
// Tank sensors: level contacts and an analogue transducer.
module fpl_level_model #(
   parameter logic [15:0] MIN_LVL = 16'h0010,  // Ascending.
   parameter logic [15:0] LOW_LVL = 16'h0020,
   parameter logic [15:0] STA_LVL = 16'h0040,
   parameter logic [15:0] STO_LVL = 16'h0080,
   parameter logic [15:0] HI_LVL  = 16'h00C0
)(
   // Tank level from the bench, then sensor outputs.
   input  wire logic [15:0] fuel_level,
   output logic [15:0]      level_value,
   output logic             minimum_level_contact,
   output logic             low_level_contact,
   output logic             pump_start_contact,
   output logic             pump_stop_contact,
   output logic             high_level_contact
);
   // Contacts follow the level at once; there is no bounce.
   assign level_value           = fuel_level;
   assign minimum_level_contact = fuel_level < MIN_LVL;
   assign low_level_contact     = fuel_level < LOW_LVL;
   assign pump_start_contact    = fuel_level < STA_LVL;
   assign pump_stop_contact     = fuel_level < STO_LVL;
   assign high_level_contact    = fuel_level > HI_LVL;
endmodule : fpl_level_model

// [sim/tb_fuel_pump_level_controller.sv]
`timescale 1ns/1ps
// ==========================================================
// Bench for the fuel pump controller.
module tb_fuel_pump_level_controller;
   import fpl_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic gen = 0, blk = 0, pready, pslverr, re, p, v, ta, ba, ev, evf;
   logic minimum_level_contact, low_level_contact, pump_start_contact;
   logic pump_stop_contact, high_level_contact;
   logic [7:0] paddr = 0;
   logic [15:0] lvl = 16'h0060, level_value;
   logic [31:0] pwdata = 0, prdata, rq;
   int err_count = 0, compares = 0, cyc = 0, on_cnt = 0, off_cnt = 0;
   always #50 pclk = ~pclk;
   // Counts pump event pulses and cuts a hang short.
   always @(posedge pclk) begin
      on_cnt <= on_cnt + int'(ev === 1'b1);
      off_cnt <= off_cnt + int'(evf === 1'b1);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         report_and_stop();
      end
   end
   fpl_level_model i_fpl_level_model (.fuel_level(lvl), .level_value,
      .minimum_level_contact, .low_level_contact, .pump_start_contact,
      .pump_stop_contact, .high_level_contact);
   fpl_ctrl #(.TICK_CYCLES(10)) i_fpl_ctrl (.pclk, .presetn, .paddr,
      .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .level_value, .minimum_level_contact, .low_level_contact,
      .pump_start_contact, .pump_stop_contact, .high_level_contact,
      .generator_present(gen), .pump_block_input(blk),
      .pump_output_function(p), .line_valve_output_function(v),
      .fill_timeout_prealarm(ta), .pump_block_prealarm(ba),
      .pump_on_event(ev), .pump_off_event(evf));
   task automatic chk(input string nm, input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // One APB transfer, entered just after a rising edge.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rq = prdata;
      re = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask : apb
   // Sets the level, waits for the pump state, holds, then checks.
   task automatic go(input logic [15:0] l, input logic e, input int h);
      int n;
      n = 0;
      lvl <= l;
      do begin
         @(posedge pclk);
         n++;
      end while (p !== e && n < 80);
      repeat (h) @(posedge pclk);
      chk("pump", p, e);
   endtask : go
   function automatic logic [31:0] cfg(input logic [1:0] m,
                                       input logic s, input logic [2:0] r);
      return 32'h0000_1F04 | {25'h0, r, s, 1'b0, m};
   endfunction : cfg
   task automatic report_and_stop();
      $display("compares %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   task automatic s_regs();
      logic [7:0] o[5] = '{FPL_START_OFS, FPL_STOP_OFS, FPL_MIN_OFS,
                           FPL_LOW_OFS, FPL_HIGH_OFS};
      logic [15:0] t[5] = '{16'h0040, 16'h0080, 16'h0010, 16'h0020,
                            16'h00C0};
      chk("pump", p, 0);
      apb(0, FPL_CTRL_OFS, 0);
      chk("ctrl", rq, 0);
      for (int i = 0; i < 5; i++) begin
         apb(1, o[i], {16'h0, t[i]});
         apb(0, o[i], 0);
         chk("thr", rq, {16'h0, t[i]});
      end
      apb(0, 8'h2C, 0);
      chk("slverr", re, 1);
   endtask : s_regs
   task automatic s_auto();
      int n0, n1;
      apb(1, FPL_VDLY_OFS, 2);
      for (int s = 0; s < 2; s++) begin
         apb(1, FPL_CTRL_OFS, cfg(0, 1'(s), FPL_SRC_ALW) | 32'h80);
         n0 = on_cnt;
         n1 = off_cnt;
         go(16'h0030, 1, 2);
         chk("valve", v, 1);
         chk("event", 32'(on_cnt - n0), 1);
         go(16'h0060, 1, 20);
         go(16'h0090, 0, 0);
         chk("valve", v, 1);
         go(16'h0060, 0, 20);
         chk("off_event", 32'(off_cnt - n1), 1);
         go(16'h0005, 1, 0);
         go(16'h00D0, 0, 0);
      end
   endtask : s_auto
   task automatic s_misc();
      apb(1, FPL_CTRL_OFS, cfg(2'h3, 1, FPL_SRC_ALW));
      go(16'h0005, 0, 40);
      apb(1, FPL_CTRL_OFS, cfg(FPL_MODE_RUN, 1, FPL_SRC_ALW));
      go(16'h0060, 1, 0);
      go(16'h0090, 0, 0);
      go(16'h0060, 1, 0);
      apb(1, FPL_CTRL_OFS, cfg(0, 1, FPL_SRC_GEN));
      go(16'h0030, 0, 40);
      gen <= 1;
      go(16'h0030, 1, 0);
      gen <= 0;
      repeat (4) @(posedge pclk);
      chk("pump", p, 0);
      gen <= 1;
      go(16'h0030, 1, 0);
      apb(1, FPL_CTRL_OFS, cfg(0, 1, FPL_SRC_GEN) & ~32'h4);
      repeat (2) @(posedge pclk);
      chk("pump", p, 0);
   endtask : s_misc
   task automatic s_oper();
      int n0;
      apb(1, FPL_CTRL_OFS, cfg(0, 1, FPL_SRC_ALW));
      go(16'h0090, 0, 20);
      go(16'h0060, 0, 20);
      apb(1, FPL_CMD_OFS, 1);
      go(16'h0060, 1, 0);
      apb(1, FPL_CMD_OFS, 2);
      go(16'h0060, 0, 0);
      go(16'h0090, 0, 20);
      // A refused start must not even flash the pump on.
      n0 = on_cnt;
      apb(1, FPL_CMD_OFS, 1);
      go(16'h0090, 0, 40);
      chk("on_event", 32'(on_cnt - n0), 0);
      apb(1, FPL_MAXON_OFS, 3);
      go(16'h0030, 1, 0);
      go(16'h0030, 0, 0);
      chk("timeout", ta, 1);
      apb(1, FPL_CMD_OFS, 4);
      go(16'h0030, 1, 0);
      apb(1, FPL_MAXON_OFS, 0);
      apb(1, FPL_CMD_OFS, 4);
      apb(1, FPL_BDLY_OFS, 2);
      blk <= 1;
      go(16'h0030, 0, 0);
      chk("block", ba, 1);
      blk <= 0;
      go(16'h0030, 1, 0);
   endtask : s_oper
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      s_regs();
      s_auto();
      s_misc();
      s_oper();
      report_and_stop();
   end
endmodule : tb_fuel_pump_level_controller
